// File: verilog/cpu_seq_defines.svh
// Constants for the machine-cycle sequencer: status bit positions, counter reset value, restart opcode match, synchroniser depth.
// Assumes one system clock where each state lasts one clock (phase one then phase two).
// Notes on behaviour
// RL1: Each machine cycle passes T1, T2, T3, plus wait states while not ready.
// RL2: Cycle ends after T3, T4 or T5, going straight to next T1.
// RL3: In T1 drive address on address bus and status byte on data bus (the sequencer drives no status in the first T1 after reset).
// RL4: In T2 sample ready and bus-release request, check for stop instruction.
// RL5: Insert wait after T2 when ready low or stop instruction executed.
// RL6: T3 reads instruction, data or interrupt byte, or drives write data out.
// RL7: T4 and T5 are internal only, skipped singly or together when unneeded.
// RL8: Interrupt request is asynchronous and resynchronised before use.
// RL9: Synced request sets interrupt latch only when enabled, at instruction's last state.
// RL10: Interrupt cycle looks like fetch with opcode-fetch and acknowledge status bits.
// RL11: Interrupt cycle puts program counter out in T1 without incrementing it.
// RL12: External logic jams an eight-bit interrupt instruction onto data bus in T3.
// RL13: Restart call's three-bit field selects vector 0..56 step 8; old counter pushed.
// RL14: Accepted bus-release raises acknowledge and floats address and data buses.
// RL15: Hold latch sets on ready, synced request and phase two; next phase one acknowledges.
// RL16: Acknowledge at T3 for reads, else after T3; buses float one phase later (the sequencer floats them one full clock later).
// RL17: Acknowledged at T3 in long cycle, internal work runs through T4 and T5.
// RL18: Master drops request when done; acknowledge drops, next machine cycle resumes.
// RL19: After stop instruction, halt is entered after T2 of next cycle.
// RL20: Reset always returns to T1 and clears the program counter, even from halt.
// RL21: Bus-release request in halt enters hold; on release, halt is re-entered.
// RL22: Enabled interrupt leaves halt to T1; with flag clear only reset exits.
// RL23: Cycle-start strobe marks T1 of every machine cycle with status on data bus (the sequencer drives no status in the first T1 after reset).
// RL24: One state lasts one clock period holding one phase-one and one phase-two.
`ifndef CPU_SEQ_DEFINES_SVH
`define CPU_SEQ_DEFINES_SVH
`define ST_ACK_BIT 0
`define ST_WO_N_BIT 1
`define ST_STACK_BIT 2
`define ST_HALT_ACK_BIT 3
`define ST_OUT_BIT 4
`define ST_FETCH_BIT 5
`define ST_INP_BIT 6
`define ST_MEMR_BIT 7
`define PC_RESET 16'h0000
`define RST_OPCODE_MASK 8'hC7
`define RST_OPCODE_VAL 8'hC7
`define SYNC_STAGES 2
`endif

// File: verilog/cpu_seq_pkg.sv
// Types shared by the machine-cycle sequencer.
// Assumes the defines header is compiled alongside.
package cpu_seq_pkg;
    typedef enum logic [2:0] {
        ST_T1 = 3'b000,
        ST_T2 = 3'b001,
        ST_TW = 3'b010,
        ST_T3 = 3'b011,
        ST_T4 = 3'b100,
        ST_T5 = 3'b101,
        ST_HALT = 3'b110,
        ST_HOLD = 3'b111
    } tstate_e;
    typedef enum logic [2:0] {
        CYC_FETCH = 3'b000,
        CYC_MEM_READ = 3'b001,
        CYC_MEM_WRITE = 3'b010,
        CYC_STACK_READ = 3'b011,
        CYC_STACK_WRITE = 3'b100,
        CYC_INPUT = 3'b101,
        CYC_OUTPUT = 3'b110
    } cycle_e;
endpackage

// File: verilog/level_sync.sv
// Two-flop synchroniser for a level from another timing domain.
// Assumes the destination clock is clk.
`timescale 1ns/1ps
module level_sync #(
    parameter int STAGES = 2
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic din,
    output logic dout
);
    logic [STAGES-1:0] chain_q;

    always_ff @(posedge clk) begin
        if (reset) begin
            chain_q <= '0;
        end else begin
            chain_q <= {chain_q[STAGES-2:0], din};
        end
    end

    assign dout = chain_q[STAGES-1];
endmodule // level_sync

// File: verilog/cpu_machine_cycle_sequencer.sv
// Machine-cycle sequencer: T-states, waits, interrupt acceptance, bus hold, halt.
// Assumes each clk period is one T state (phase one = first half, phase two = second);
// instruction decode supplies the cycle kind and length on the cycle_* inputs.
`timescale 1ns/1ps
`include "cpu_seq_defines.svh"
module cpu_machine_cycle_sequencer
    import cpu_seq_pkg::*;
#(
    parameter int ADDR_W = 16,
    parameter int DATA_W = 8
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic ready,
    input wire logic hold_request,
    input wire logic int_request,
    input wire logic interrupt_enable_flag,
    input wire logic [2:0] cycle_kind,
    input wire logic [2:0] cycle_states,
    input wire logic last_cycle,
    input wire logic stop_instruction,
    input wire logic pc_load,
    input wire logic [ADDR_W-1:0] pc_load_value,
    input wire logic [ADDR_W-1:0] cycle_addr,
    input wire logic use_pc,
    input wire logic [DATA_W-1:0] write_data,
    input wire logic [DATA_W-1:0] data_in,
    output logic [ADDR_W-1:0] addr_out,
    output logic addr_oe,
    output logic [DATA_W-1:0] data_out,
    output logic data_oe,
    output logic cycle_start,
    output logic wait_state,
    output logic halt_state,
    output logic bus_release_acknowledge,
    output logic [2:0] tstate,
    output logic [DATA_W-1:0] read_byte,
    output logic read_valid,
    output logic interrupt_cycle,
    output logic [ADDR_W-1:0] pc,
    output logic [ADDR_W-1:0] restart_vector,
    output logic restart_valid,
    output logic cycle_done
);
    tstate_e state_q, state_d;
    logic int_sync;
    logic hold_sync;
    logic int_latch_q;
    logic hold_latch_q;
    logic halt_pending_q;
    logic interrupt_ack_status_bit_cycle_q;
    logic ack_q;
    logic float_q;
    logic [2:0] kind_q;
    logic [2:0] nstates_q;
    logic [ADDR_W-1:0] pc_q;
    logic [ADDR_W-1:0] addr_q;
    logic [DATA_W-1:0] dout_q;
    logic doe_q;
    logic sync_q;
    logic [DATA_W-1:0] rbyte_q;
    logic rvalid_q;
    logic [ADDR_W-1:0] rvec_q;
    logic rst_valid_q;
    logic done_q;
    logic is_read;
    logic end_of_cycle;
    logic [DATA_W-1:0] status_byte;
    logic int_take;
    logic int_next;
    logic wait_q;
    logic halt_q;

    // Interrupt and hold inputs arrive asynchronously.
    level_sync #(.STAGES(`SYNC_STAGES)) u_int_sync ( // see RL8
        .clk(clk),
        .reset(reset),
        .din(int_request),
        .dout(int_sync)
    );
    level_sync #(.STAGES(`SYNC_STAGES)) u_hold_sync (
        .clk(clk),
        .reset(reset),
        .din(hold_request),
        .dout(hold_sync)
    );

    assign is_read = (kind_q == CYC_FETCH) || (kind_q == CYC_MEM_READ) ||
                     (kind_q == CYC_STACK_READ) || (kind_q == CYC_INPUT);

    // The cycle ends after its last needed state: T3, T4 or T5.
    always_comb begin
        end_of_cycle = 1'b0; // see RL2
        if (state_q == ST_T3 && nstates_q <= 3'd3) begin
            end_of_cycle = 1'b1;
        end else if (state_q == ST_T4 && nstates_q == 3'd4) begin
            end_of_cycle = 1'b1;
        end else if (state_q == ST_T5) begin
            end_of_cycle = 1'b1;
        end
    end

    // A request taken at this edge must already mark the status of the T1 that it opens.
    assign int_take = (int_sync && interrupt_enable_flag && end_of_cycle && last_cycle) ||
        (state_q == ST_HALT && !hold_sync && int_sync && interrupt_enable_flag);
    assign int_next = int_latch_q || int_take;

    always_comb begin
        status_byte = '0; // see RL10
        status_byte[`ST_ACK_BIT] = int_next;
        status_byte[`ST_WO_N_BIT] = !(cycle_kind == CYC_MEM_WRITE ||
            cycle_kind == CYC_STACK_WRITE || cycle_kind == CYC_OUTPUT);
        status_byte[`ST_STACK_BIT] = (cycle_kind == CYC_STACK_READ) ||
            (cycle_kind == CYC_STACK_WRITE);
        status_byte[`ST_HALT_ACK_BIT] = halt_pending_q;
        status_byte[`ST_OUT_BIT] = (cycle_kind == CYC_OUTPUT);
        status_byte[`ST_FETCH_BIT] = (cycle_kind == CYC_FETCH) || int_next;
        status_byte[`ST_INP_BIT] = (cycle_kind == CYC_INPUT);
        status_byte[`ST_MEMR_BIT] = (cycle_kind == CYC_FETCH || cycle_kind == CYC_MEM_READ ||
            cycle_kind == CYC_STACK_READ) && !int_next;
    end

    // One state per clock; phase one and phase two fall within the same period.
    always_comb begin
        state_d = state_q; // see RL24
        case (state_q)
            ST_T1: state_d = ST_T2; // see RL1
            ST_T2: begin
                if (halt_pending_q) begin
                    state_d = ST_HALT; // see RL19
                end else if (!ready) begin
                    state_d = ST_TW; // see RL5
                end else begin
                    state_d = ST_T3;
                end
            end
            ST_TW: state_d = ready ? ST_T3 : ST_TW;
            ST_T3, ST_T4, ST_T5: begin
                if (!end_of_cycle) begin
                    state_d = (state_q == ST_T3) ? ST_T4 : ST_T5; // see RL7
                end else if (hold_latch_q) begin
                    state_d = ST_HOLD; // see RL17
                end else begin
                    state_d = ST_T1; // see RL2
                end
            end
            ST_HALT: begin
                if (hold_sync) begin
                    state_d = ST_HOLD; // see RL21
                end else if (int_sync && interrupt_enable_flag) begin
                    state_d = ST_T1; // see RL22
                end
            end
            ST_HOLD: begin
                if (!hold_sync) begin
                    state_d = halt_pending_q ? ST_HALT : ST_T1; // see RL18 RL21
                end
            end
            default: state_d = ST_T1;
        endcase
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            state_q <= ST_T1; // see RL20
        end else begin
            state_q <= state_d;
        end
    end

    // Cycle description is captured at T1 so it stays fixed across waits.
    always_ff @(posedge clk) begin
        if (reset) begin
            kind_q <= CYC_FETCH;
            nstates_q <= 3'd4;
            interrupt_ack_status_bit_cycle_q <= 1'b0;
        end else if (state_q == ST_T1) begin
            kind_q <= int_latch_q ? CYC_FETCH : cycle_kind;
            nstates_q <= (cycle_states < 3'd3) ? 3'd3 : cycle_states; // see RL1
            interrupt_ack_status_bit_cycle_q <= int_latch_q;
        end
    end

    // Halt is armed by the stop instruction and entered after the next T2.
    always_ff @(posedge clk) begin
        if (reset) begin
            halt_pending_q <= 1'b0;
        end else if (state_q == ST_T2 && stop_instruction) begin
            halt_pending_q <= 1'b1; // see RL4
        end else if (state_q == ST_HALT && !hold_sync && int_sync && interrupt_enable_flag) begin
            halt_pending_q <= 1'b0;
        end
    end

    // Latch at the instruction's final state, or in halt, so the instruction completes.
    always_ff @(posedge clk) begin
        if (reset) begin
            int_latch_q <= 1'b0;
        end else if (int_sync && interrupt_enable_flag && end_of_cycle && last_cycle) begin
            int_latch_q <= 1'b1; // see RL9
        end else if (state_q == ST_HALT && int_sync && interrupt_enable_flag) begin
            int_latch_q <= 1'b1; // see RL22
        end else if (state_q == ST_T1) begin
            int_latch_q <= 1'b0;
        end
    end

    // Hold latch needs ready and the synced request together, sampled in T2 and wait states; in halt the request alone sets it.
    always_ff @(posedge clk) begin
        if (reset) begin
            hold_latch_q <= 1'b0;
        end else if ((state_q == ST_T2 || state_q == ST_TW) && ready && hold_sync) begin
            hold_latch_q <= 1'b1; // see RL15
        end else if (state_q == ST_HALT && hold_sync) begin
            hold_latch_q <= 1'b1;
        end else if (!hold_sync && (state_q == ST_HOLD || state_q == ST_T1)) begin
            hold_latch_q <= 1'b0;
        end
    end

    // Acknowledge at T3 for reads, otherwise in the state after T3. For a read the
    // latch and the acknowledge rise at the same edge, the one that opens T3.
    always_ff @(posedge clk) begin
        if (reset) begin
            ack_q <= 1'b0;
        end else if (!hold_sync) begin
            ack_q <= 1'b0; // see RL18
        end else if (is_read && (state_q == ST_T2 || state_q == ST_TW) && ready) begin
            ack_q <= 1'b1; // see RL16
        end else if (hold_latch_q && (state_q == ST_T3 || state_q == ST_HALT ||
            state_q == ST_HOLD)) begin
            ack_q <= 1'b1; // see RL14
        end
    end

    // Buses float one clock after acknowledge and return with its fall, so the
    // resumed T1 already drives address and status.
    always_ff @(posedge clk) begin
        if (reset) begin
            float_q <= 1'b0;
        end else if (!hold_sync) begin
            float_q <= 1'b0; // see RL18
        end else begin
            float_q <= ack_q; // see RL16
        end
    end

    // The counter steps in T2 of a fetch, but never in an interrupt cycle.
    always_ff @(posedge clk) begin
        if (reset) begin
            pc_q <= `PC_RESET; // see RL20
        end else if (pc_load) begin
            pc_q <= pc_load_value;
        end else if (state_q == ST_T2 && kind_q == CYC_FETCH && !interrupt_ack_status_bit_cycle_q) begin
            pc_q <= pc_q + 1'b1; // see RL11
        end
    end

    // Address and status are presented from T1 onward.
    always_ff @(posedge clk) begin
        if (reset) begin
            addr_q <= '0;
            dout_q <= '0;
            doe_q <= 1'b0;
            // Reset holds the sequencer in T1, so the strobe already marks it.
            sync_q <= 1'b1;
        end else begin
            sync_q <= (state_d == ST_T1); // see RL23
            if (state_d == ST_T1) begin
                addr_q <= (use_pc || int_next || (state_q == ST_HALT)) ? pc_q : cycle_addr;
                dout_q <= status_byte; // see RL3
                doe_q <= 1'b1;
            end else if (state_d == ST_T2 || state_d == ST_TW || state_d == ST_T3) begin
                dout_q <= write_data;
                doe_q <= !is_read; // see RL6
            end else if (state_d == ST_HALT || state_d == ST_HOLD) begin
                doe_q <= 1'b0;
            end
        end
    end

    // Read data is taken in T3; an interrupt cycle takes the jammed instruction.
    always_ff @(posedge clk) begin
        if (reset) begin
            rbyte_q <= '0;
            rvalid_q <= 1'b0;
            rvec_q <= '0;
            rst_valid_q <= 1'b0;
        end else begin
            rvalid_q <= (state_q == ST_T3) && is_read;
            rst_valid_q <= 1'b0;
            if (state_q == ST_T3 && is_read) begin
                rbyte_q <= data_in; // see RL6 RL12
                if (interrupt_ack_status_bit_cycle_q && (data_in & `RST_OPCODE_MASK) == `RST_OPCODE_VAL) begin
                    rvec_q <= {{(ADDR_W-6){1'b0}}, data_in[5:3], 3'b000}; // see RL13
                    rst_valid_q <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            done_q <= 1'b0;
        end else begin
            done_q <= end_of_cycle;
        end
    end

    // State flags are registered from the next state so the pins carry no decode glitches.
    always_ff @(posedge clk) begin
        if (reset) begin
            wait_q <= 1'b0;
            halt_q <= 1'b0;
        end else begin
            wait_q <= (state_d == ST_TW); // see RL5
            halt_q <= (state_d == ST_HALT); // see RL19
        end
    end

    assign addr_out = addr_q;
    assign addr_oe = !float_q; // see RL14
    assign data_out = dout_q;
    assign data_oe = doe_q && !float_q;
    assign cycle_start = sync_q;
    assign wait_state = wait_q;
    assign halt_state = halt_q;
    assign bus_release_acknowledge = ack_q;
    assign tstate = state_q;
    assign read_byte = rbyte_q;
    assign read_valid = rvalid_q;
    assign interrupt_cycle = interrupt_ack_status_bit_cycle_q;
    assign pc = pc_q;
    assign restart_vector = rvec_q;
    assign restart_valid = rst_valid_q;
    assign cycle_done = done_q;

    a_reset_to_t1: assert property (@(posedge clk) reset |=> state_q == ST_T1 && pc_q == '0) // see RL20
        else $error("reset did not return to T1 with cleared counter");
    a_t2_not_ready: assert property (@(posedge clk) disable iff (reset) // see RL5
        state_q == ST_T2 && !ready && !halt_pending_q |=> state_q == ST_TW)
        else $error("no wait state after T2 with ready low");
    sequence s_t1_t2;
        state_q == ST_T1 ##1 state_q == ST_T2;
    endsequence
    a_cycle_min: assert property (@(posedge clk) disable iff (reset) // see RL1
        state_q == ST_T1 && !$past(reset) |=> state_q == ST_T2)
        else $error("T1 not followed by T2");
    a_sync_marks: assert property (@(posedge clk) disable iff (reset) // see RL23
        s_t1_t2 |-> $past(cycle_start))
        else $error("cycle start strobe missing in T1");
    a_no_inc_int: assert property (@(posedge clk) disable iff (reset) // see RL11
        state_q == ST_T2 && interrupt_ack_status_bit_cycle_q && !pc_load |=> pc_q == $past(pc_q))
        else $error("counter moved during interrupt cycle");
    a_float_after: assert property (@(posedge clk) disable iff (reset) // see RL16
        $rose(ack_q) |=> !addr_oe)
        else $error("buses not floated after acknowledge");
    a_halt_entry: assert property (@(posedge clk) disable iff (reset) // see RL19
        state_q == ST_T2 && halt_pending_q |=> state_q == ST_HALT)
        else $error("halt not entered after T2");
    a_halt_stuck: assert property (@(posedge clk) disable iff (reset) // see RL22
        state_q == ST_HALT && !interrupt_enable_flag && !hold_sync |=> state_q == ST_HALT)
        else $error("halt left without enable or hold");
    a_end_to_t1: assert property (@(posedge clk) disable iff (reset) // see RL2
        end_of_cycle && !hold_latch_q |=> state_q == ST_T1)
        else $error("cycle end did not go to T1");
endmodule // cpu_machine_cycle_sequencer

// File: sim/bus_partner.sv
// Memory, interrupt source and bus master that answer the sequencer's bus.
// Assumes the bench sets the wait count, interrupt byte and bus request.
`timescale 1ns/1ps
module bus_partner
    import cpu_seq_pkg::*;
(
    input wire logic clk,
    input wire logic [2:0] tstate,
    input wire logic [15:0] addr_out,
    input wire logic interrupt_cycle,
    input wire logic [31:0] wait_n,
    input wire logic [7:0] jam_byte,
    input wire logic dma_req,
    output logic ready,
    output logic hold_request,
    output logic [7:0] data_in
);
    logic [31:0] cnt_q = 0;
    logic [7:0] last_q = 8'h00;
    logic [7:0] mem_byte;
    assign ready = (cnt_q == 0);
    assign mem_byte = addr_out[7:0] ^ addr_out[15:8] ^ 8'h3c;
    // Outside T3 nobody holds the bus, so it shows a value that flips every cycle.
    assign data_in = (tstate != ST_T3) ? ~last_q : interrupt_cycle ? jam_byte : mem_byte;
    always @(posedge clk) begin
        last_q <= data_in;
        if (tstate == ST_T1) begin
            cnt_q <= wait_n;
        end else if ((tstate == ST_T2 || tstate == ST_TW) && cnt_q != 0) begin
            cnt_q <= cnt_q - 1;
        end
    end
    initial hold_request = 1'b0;
    // The request moves off the clock grid, as a real bus master's would.
    always @(dma_req) hold_request <= #3 dma_req;
endmodule // bus_partner

// File: sim/testbench.sv
// Self-checking bench for the machine-cycle sequencer.
// Assumes the bus partner model stands at the far side of the bus.
`timescale 1ns/1ps
`include "cpu_seq_defines.svh"
module testbench
    import cpu_seq_pkg::*;
;
    logic clk = 0;
    logic reset = 1;
    logic int_request = 0;
    logic interrupt_enable_flag = 0;
    logic [2:0] cycle_kind = CYC_MEM_READ;
    logic [2:0] cycle_states = 3'h3;
    logic last_cycle = 1;
    logic stop_instruction = 0;
    logic pc_load = 0;
    logic [15:0] pc_load_value = 16'h0000;
    logic [15:0] cycle_addr = 16'h0000;
    logic use_pc = 0;
    logic [7:0] write_data = 8'h00;
    logic [31:0] wait_n = 0;
    logic [7:0] jam_byte = 8'h00;
    logic dma_req = 0;
    logic ready, hold_request, addr_oe, data_oe, cycle_start, halt_state;
    logic bus_release_acknowledge, read_valid, interrupt_cycle, restart_valid, wait_state;
    logic cycle_done;
    logic [15:0] addr_out, pc, restart_vector, exp_pc;
    logic [7:0] data_out, read_byte, data_in;
    logic [2:0] tstate;
    logic [31:0] seed_q = 32'h0000_b9b8;
    int n_fail = 0;
    int tests_run = 0;
    int cyc_n = 0;
    always #4 clk = ~clk;
    cpu_machine_cycle_sequencer i_cpu_machine_cycle_sequencer (.clk(clk), .reset(reset),
        .ready(ready), .hold_request(hold_request), .int_request(int_request),
        .interrupt_enable_flag(interrupt_enable_flag), .cycle_kind(cycle_kind),
        .cycle_states(cycle_states), .last_cycle(last_cycle),
        .stop_instruction(stop_instruction), .pc_load(pc_load), .pc_load_value(pc_load_value),
        .cycle_addr(cycle_addr), .use_pc(use_pc), .write_data(write_data), .data_in(data_in),
        .addr_out(addr_out), .addr_oe(addr_oe), .data_out(data_out), .data_oe(data_oe),
        .cycle_start(cycle_start), .wait_state(wait_state), .halt_state(halt_state),
        .bus_release_acknowledge(bus_release_acknowledge), .tstate(tstate),
        .read_byte(read_byte), .read_valid(read_valid), .interrupt_cycle(interrupt_cycle),
        .pc(pc), .restart_vector(restart_vector), .restart_valid(restart_valid),
        .cycle_done(cycle_done));
    bus_partner i_bus_partner (.clk(clk), .tstate(tstate), .addr_out(addr_out),
        .interrupt_cycle(interrupt_cycle), .wait_n(wait_n), .jam_byte(jam_byte),
        .dma_req(dma_req), .ready(ready), .hold_request(hold_request), .data_in(data_in));
    function logic [31:0] rnd();
        seed_q = seed_q ^ (seed_q << 13);
        seed_q = seed_q ^ (seed_q >> 17);
        seed_q = seed_q ^ (seed_q << 5);
        return seed_q;
    endfunction
    function automatic logic [7:0] status(input logic [2:0] k);
        logic [7:0] s;
        s = 8'h00;
        s[`ST_MEMR_BIT] = k inside {CYC_FETCH, CYC_MEM_READ, CYC_STACK_READ};
        s[`ST_INP_BIT] = (k == CYC_INPUT);
        s[`ST_FETCH_BIT] = (k == CYC_FETCH);
        s[`ST_OUT_BIT] = (k == CYC_OUTPUT);
        s[`ST_STACK_BIT] = k inside {CYC_STACK_READ, CYC_STACK_WRITE};
        s[`ST_WO_N_BIT] = !(k inside {CYC_MEM_WRITE, CYC_STACK_WRITE, CYC_OUTPUT});
        return s;
    endfunction
    function automatic logic sig(input int w);
        case (w)
            0: return bus_release_acknowledge;
            1: return halt_state;
            2: return cycle_start;
            4: return restart_valid;
            5: return interrupt_cycle;
            6: return tstate === ST_HOLD;
            default: return tstate === ST_T1;
        endcase
    endfunction
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic step();
        @(posedge clk);
        #1;
    endtask
    task automatic wait_for(input string what, input int w, input logic v, input int lim);
        int n;
        n = 0;
        while (sig(w) !== v && n < lim) begin
            step();
            n++;
        end
        check(what, sig(w), v);
    endtask
    // Status is compared on the second of two like cycles only, so it does not
    // matter on which edge the design takes the cycle kind.
    task automatic run_cycle(input logic [2:0] kind, input int st, input int wt, input bit chk);
        int n;
        int nw;
        logic rd;
        logic [31:0] r;
        logic [15:0] ea;
        r = rnd();
        rd = kind inside {CYC_FETCH, CYC_MEM_READ, CYC_STACK_READ, CYC_INPUT};
        // The address of this T1 was latched from the settings in force as it began.
        ea = use_pc ? exp_pc : cycle_addr;
        if (!chk) cycle_addr = r[31:16];
        cycle_kind = kind;
        cycle_states = st[2:0];
        use_pc = (kind == CYC_FETCH);
        write_data = r[7:0];
        wait_n = wt;
        if (chk) check("status", data_out, status(kind));
        if (chk) check("status drive", data_oe, 1'b1);
        n = 0;
        nw = 0;
        do begin
            step();
            n++;
            if (n == 1) check("addr", addr_out, ea);
            if (wait_state === 1'b1) nw++;
            if (read_valid === 1'b1) check("read", read_byte, ea[7:0] ^ ea[15:8] ^ 8'h3c);
            if (tstate === ST_T3 && !rd) check("write", data_out, r[7:0]);
        end while (cycle_start !== 1'b1 && n < 40);
        check("length", 16'(n), 16'(st + wt));
        check("waits", 16'(nw), 16'(wt));
        check("done", cycle_done, 1'b1);
        if (use_pc) exp_pc = exp_pc + 16'h0001;
        if (use_pc) check("pc step", pc, exp_pc);
    endtask
    always @(posedge clk) begin
        cyc_n++;
        if (cyc_n == 5000) begin
            n_fail++;
            give_verdict();
        end
    end
    initial begin
        logic [31:0] r;
        logic [15:0] pcv;
        int k;
        repeat (12) @(posedge clk);
        #1;
        reset = 0;
        check("reset state", tstate, ST_T1);
        check("reset pc", pc, 16'h0000);
        wait_for("start", 2, 1'b1, 8);
        r = rnd();
        pc_load = 1;
        pc_load_value = r[15:0];
        step();
        pc_load = 0;
        check("pc load", pc, r[15:0]);
        exp_pc = r[15:0];
        wait_for("start", 2, 1'b1, 8);
        for (int p = 0; p < 3; p++) begin
            for (k = 0; k < 7; k++) begin
                r = rnd();
                run_cycle(k[2:0], 3 + r[1:0] % 3, r[3:2], 0);
                run_cycle(k[2:0], 3 + r[1:0] % 3, r[3:2], 1);
            end
        end
        for (k = 0; k < 2; k++) begin
            cycle_kind = k ? CYC_MEM_WRITE : CYC_MEM_READ;
            cycle_states = k ? 3'h3 : 3'h5;
            wait_n = 0;
            dma_req = 1;
            wait_for("ack", 0, 1'b1, 30);
            check("ack state", tstate, k ? ST_HOLD : ST_T3);
            step();
            check("addr float", addr_oe, 1'b0);
            check("data float", data_oe, 1'b0);
            if (k == 0) begin
                check("inner T4", tstate, ST_T4);
                step();
                check("inner T5", tstate, ST_T5);
            end
            wait_for("hold", 6, 1'b1, 4);
            dma_req = 0;
            wait_for("ack drop", 0, 1'b0, 8);
            wait_for("resume", 2, 1'b1, 8);
        end
        for (k = 0; k < 8; k++) begin
            cycle_kind = CYC_FETCH;
            cycle_states = 3'h3;
            use_pc = 1;
            jam_byte = 8'hc7 | 8'(k << 3);
            interrupt_enable_flag = 1;
            int_request = 1;
            step();
            wait_for("int start", 2, 1'b1, 8);
            check("int ack bit", data_out[`ST_ACK_BIT], 1'b1);
            check("int fetch bit", data_out[`ST_FETCH_BIT], 1'b1);
            wait_for("int cycle", 5, 1'b1, 40);
            // Enable drops before this cycle ends so that no second one follows.
            int_request = 0;
            interrupt_enable_flag = 0;
            pcv = pc;
            wait_for("restart", 4, 1'b1, 12);
            check("vector", restart_vector, 16'(k * 8));
            check("pc kept", pc, pcv);
            wait_for("start", 2, 1'b1, 8);
        end
        for (k = 0; k < 2; k++) begin
            interrupt_enable_flag = k[0];
            stop_instruction = 1;
            step();
            wait_for("start", 2, 1'b1, 8);
            stop_instruction = 0;
            wait_for("halt", 1, 1'b1, 8);
            int_request = 1;
            if (k == 1) begin
                wait_for("wake", 7, 1'b1, 8);
                wait_for("wake int", 5, 1'b1, 4);
            end else begin
                repeat (10) step();
                check("halt kept", halt_state, 1'b1);
                int_request = 0;
                dma_req = 1;
                wait_for("halt ack", 0, 1'b1, 12);
                dma_req = 0;
                wait_for("halt ack drop", 0, 1'b0, 8);
                wait_for("halt again", 1, 1'b1, 8);
                reset = 1;
                repeat (3) step();
                reset = 0;
                check("halt reset", tstate, ST_T1);
                check("halt reset pc", pc, 16'h0000);
                wait_for("start", 2, 1'b1, 8);
            end
            int_request = 0;
        end
        give_verdict();
    end
endmodule // testbench
